// ===== inc/ppchv_pkg.sv
package ppchv_pkg;
   // ==========================================================
   // geometry
   localparam int NPIN = 6;
   localparam int NHC  = 3;
   // ==========================================================
   // register byte offsets
   localparam logic [7:0] OFS_DATA      = 8'h00;
   localparam logic [7:0] OFS_INPUT     = 8'h04;
   localparam logic [7:0] OFS_DIR       = 8'h08;
   localparam logic [7:0] OFS_PULL_EN   = 8'h0C;
   localparam logic [7:0] OFS_PULL_SEL  = 8'h10;
   localparam logic [7:0] OFS_EV_EN     = 8'h14;
   localparam logic [7:0] OFS_EV_FLAG   = 8'h18;
   localparam logic [7:0] OFS_DRV_RED   = 8'h1C;
   localparam logic [7:0] OFS_OPEN_DR   = 8'h20;
   localparam logic [7:0] OFS_HV_AEN    = 8'h24;
   localparam logic [7:0] OFS_HV_DIR    = 8'h28;
   localparam logic [7:0] OFS_HV_BYP    = 8'h2C;
   localparam logic [7:0] OFS_HV_TEST   = 8'h30;
   localparam logic [7:0] OFS_HV_RATIO  = 8'h34;
   localparam logic [7:0] OFS_HV_DIEN   = 8'h38;
   localparam logic [7:0] OFS_HV_POL    = 8'h3C;
   localparam logic [7:0] OFS_HV_EV_EN  = 8'h40;
   localparam logic [7:0] OFS_HV_EV_FLG = 8'h44;
   localparam logic [7:0] OFS_HV_READ   = 8'h48;
   localparam logic [7:0] OFS_EXT_CTRL  = 8'h4C;
   // ==========================================================
   // field positions
   localparam int OC_EN_P0   = 6;
   localparam int OC_EN_P2   = 7;
   localparam int EXT_EN     = 0;
   localparam int EXT_EDGE   = 1;
   localparam int EXT_PEND   = 2;
   // ==========================================================
   // reset values
   localparam logic [5:0] RST_6 = 6'h00;
   localparam logic [7:0] RST_8 = 8'h00;
   localparam logic [2:0] RST_3 = 3'h0;
   // ==========================================================
   // filter history patterns, oldest sample in bit 7
   localparam logic [7:0] HIST_RISE = 8'h0F;
   localparam logic [7:0] HIST_FALL = 8'hF0;
   // ==========================================================
   // timing
   localparam int CLK_MHZ      = 200;
   localparam int RC_PHASE_NS  = 1000;
   localparam int RC_PHASE_CYC = (RC_PHASE_NS * CLK_MHZ) / 1000;
   // ==========================================================
   // bus answers
   localparam logic [1:0] RESP_OK  = 2'b00;
   localparam logic [1:0] RESP_ERR = 2'b10;
endpackage

// ===== design/ppchv_top.sv
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ppchv_top (
   input  wire logic         aclk,            // bus clock
   input  wire logic         aresetn,         // sync reset, low
   input  wire logic [31:0]  s_axi_awaddr,    // write address
   input  wire logic         s_axi_awvalid,   // write address valid
   output logic              s_axi_awready,   // write address ready
   input  wire logic [31:0]  s_axi_wdata,     // write data
   input  wire logic [3:0]   s_axi_wstrb,     // byte enables
   input  wire logic         s_axi_wvalid,    // write data valid
   output logic              s_axi_wready,    // write data ready
   output logic [1:0]        s_axi_bresp,     // write response
   output logic              s_axi_bvalid,    // write response valid
   input  wire logic         s_axi_bready,    // write response ready
   input  wire logic [31:0]  s_axi_araddr,    // read address
   input  wire logic         s_axi_arvalid,   // read address valid
   output logic              s_axi_arready,   // read address ready
   output logic [31:0]       s_axi_rdata,     // read data
   output logic [1:0]        s_axi_rresp,     // read response
   output logic              s_axi_rvalid,    // read data valid
   input  wire logic         s_axi_rready,    // read data ready
   input  wire logic [5:0]   pin_in,          // port pin levels
   output logic [5:0]        pin_out,         // port pin drive value
   output logic [5:0]        pin_oe,          // port pin drive enable
   output logic [5:0]        pull_up_on,      // pull-up device on
   output logic [5:0]        pull_down_on,    // pull-down device on
   output logic [2:0]        drive_full,      // full drive, pins 2..0
   input  wire logic [5:0]   periph_out_en,   // compare/pwm owns pin
   input  wire logic [5:0]   periph_in_en,    // receive/int owns pin
   input  wire logic [5:0]   periph_data,     // peripheral drive value
   input  wire logic [1:0]   oc_detect,       // over-current, pins 2,0
   input  wire logic [5:0]   hv_pin_in,       // hv comparator outputs
   output logic [5:0]        hv_buffer_on,    // hv input buffer on
   output logic [5:0]        hv_analog_on,    // hv link to converter
   output logic [5:0]        hv_divider_sel,  // 1 low ratio
   output logic [5:0]        hv_direct_on,    // divider bypassed
   output logic [5:0]        hv_conv_bypass,  // impedance conv bypassed
   input  wire logic         ext_req_pin_n,   // maskable request pin
   input  wire logic         nmi_pin_n,       // non-maskable pin
   input  wire logic         nmi_unmasked,    // cpu init done
   input  wire logic         stop_mode,       // regulator in stop
   input  wire logic         rc_clk,          // filter rc oscillator
   output logic              rc_osc_enable,   // start rc oscillator
   output logic              port_p_irq,      // port pin request
   output logic              port_l_irq,      // hv port request
   output logic              oc_irq,          // over-current request
   output logic              ext_irq,         // maskable ext request
   output logic              nmi_req,         // non-maskable request
   output logic              wakeup           // stop/wait wakeup
);
   // ==========================================================
   // synchronisers
   localparam int NSYNC = 23;
   logic [NSYNC-1:0] sync1;
   logic [NSYNC-1:0] sync2;
   always_ff @(posedge aclk) begin
      sync1 <= {rc_clk, nmi_pin_n, ext_req_pin_n, oc_detect,
                hv_pin_in, pin_in, 6'h00};
      sync2 <= sync1;
   end
   logic [5:0] p_s;
   logic [5:0] l_s;
   logic [1:0] oc_s;
   logic       ext_s_n;
   logic       nmi_s_n;
   logic       rc_s;
   assign p_s     = sync2[11:6];
   assign l_s     = sync2[17:12];
   assign oc_s    = sync2[19:18];
   assign ext_s_n = sync2[20];
   assign nmi_s_n = sync2[21];
   assign rc_s    = sync2[22];

   // ==========================================================
   // registers
   logic [5:0] r_data, r_dir, r_pen, r_psel, r_od;
   logic [7:0] r_ev_en;
   logic [2:0] r_drv_red;
   logic [5:0] r_aen, r_hdir, r_byp, r_test, r_ratio, r_dien;
   logic [5:0] r_pol, r_hev_en;
   logic [1:0] r_ext;
   logic [5:0] f_p, f_l;
   logic [1:0] f_oc;
   logic       ext_pend;

   // ==========================================================
   // bus slave
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic        w_lane0;
   logic        aw_got, w_got;
   logic        wr_go;
   logic        next_aw_got, next_w_got, next_bvalid, next_rvalid;
   logic        ar_hs;
   logic [31:0] rd_val;
   logic        rd_ok;
   assign wr_go       = aw_got & w_got & ~s_axi_bvalid;
   assign ar_hs       = s_axi_arvalid & s_axi_arready;
   assign next_aw_got = aw_got ? ~wr_go : s_axi_awvalid & s_axi_awready;
   assign next_w_got  = w_got ? ~wr_go : s_axi_wvalid & s_axi_wready;
   assign next_bvalid = wr_go | (s_axi_bvalid & ~s_axi_bready);
   assign next_rvalid = ar_hs | (s_axi_rvalid & ~s_axi_rready);

   function automatic logic ppchv_mapped(input logic [31:0] a);
      ppchv_mapped = (a[31:8] == 24'h000000) && (a[1:0] == 2'b00) &&
                     (a[7:0] <= ppchv_pkg::OFS_EXT_CTRL);
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got        <= 1'b0;
         w_got         <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= ppchv_pkg::RESP_OK;
         aw_addr       <= 8'h00;
         w_data        <= 32'h0000_0000;
         w_lane0       <= 1'b0;
      end else begin
         aw_got        <= next_aw_got;
         w_got         <= next_w_got;
         s_axi_awready <= ~next_aw_got & ~next_bvalid;
         s_axi_wready  <= ~next_w_got & ~next_bvalid;
         s_axi_bvalid  <= next_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr <= ppchv_mapped(s_axi_awaddr) ? s_axi_awaddr[7:0]
                                                  : 8'hFF;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data  <= s_axi_wdata;
            w_lane0 <= s_axi_wstrb[0];
         end
         if (wr_go) begin
            s_axi_bresp <= (aw_addr == 8'hFF) ? ppchv_pkg::RESP_ERR
                                              : ppchv_pkg::RESP_OK;
         end
      end
   end

   always_comb begin
      rd_val = 32'h0000_0000;
      rd_ok  = 1'b1;
      unique case (s_axi_araddr[7:0])
         ppchv_pkg::OFS_DATA:      rd_val[5:0] = (r_dir & r_data) |
                                                 (~r_dir & p_s);
         ppchv_pkg::OFS_INPUT:     rd_val[5:0] = p_s;
         ppchv_pkg::OFS_DIR:       rd_val[5:0] = r_dir;
         ppchv_pkg::OFS_PULL_EN:   rd_val[5:0] = r_pen;
         ppchv_pkg::OFS_PULL_SEL:  rd_val[5:0] = r_psel;
         ppchv_pkg::OFS_EV_EN:     rd_val[7:0] = r_ev_en;
         ppchv_pkg::OFS_EV_FLAG:   rd_val[7:0] = {f_oc[1], f_oc[0], f_p};
         ppchv_pkg::OFS_DRV_RED:   rd_val[2:0] = r_drv_red;
         ppchv_pkg::OFS_OPEN_DR:   rd_val[5:0] = r_od;
         ppchv_pkg::OFS_HV_AEN:    rd_val[5:0] = r_aen;
         ppchv_pkg::OFS_HV_DIR:    rd_val[5:0] = r_hdir;
         ppchv_pkg::OFS_HV_BYP:    rd_val[5:0] = r_byp;
         ppchv_pkg::OFS_HV_TEST:   rd_val[5:0] = r_test;
         ppchv_pkg::OFS_HV_RATIO:  rd_val[5:0] = r_ratio;
         ppchv_pkg::OFS_HV_DIEN:   rd_val[5:0] = r_dien;
         ppchv_pkg::OFS_HV_POL:    rd_val[5:0] = r_pol;
         ppchv_pkg::OFS_HV_EV_EN:  rd_val[5:0] = r_hev_en;
         ppchv_pkg::OFS_HV_EV_FLG: rd_val[5:0] = f_l;
         ppchv_pkg::OFS_HV_READ:   rd_val[5:0] = hv_buffer_on & l_s |
                                                 ~hv_buffer_on;
         ppchv_pkg::OFS_EXT_CTRL:  rd_val[2:0] = {ext_pend, r_ext};
         default:                  rd_ok = 1'b0;
      endcase
      if (!ppchv_mapped(s_axi_araddr)) begin
         rd_ok = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= ppchv_pkg::RESP_OK;
      end else begin
         s_axi_rvalid  <= next_rvalid;
         s_axi_arready <= ~next_rvalid;
         if (ar_hs) begin
            s_axi_rdata <= rd_ok ? rd_val : 32'h0000_0000;
            s_axi_rresp <= rd_ok ? ppchv_pkg::RESP_OK
                                 : ppchv_pkg::RESP_ERR;
         end
      end
   end

   // ==========================================================
   // configuration writes, accepted at any time when byte lane 0 is strobed
   logic wr_cfg;
   assign wr_cfg = wr_go & w_lane0;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {r_data, r_dir, r_pen, r_psel, r_od} <= {5{ppchv_pkg::RST_6}};
         r_ev_en   <= ppchv_pkg::RST_8;
         r_drv_red <= ppchv_pkg::RST_3;
         {r_aen, r_hdir, r_byp, r_test, r_ratio, r_dien, r_pol,
          r_hev_en} <= {8{ppchv_pkg::RST_6}};
         r_ext     <= 2'b00;
      end else if (wr_cfg) begin
         unique case (aw_addr)
            ppchv_pkg::OFS_DATA:     r_data    <= w_data[5:0];
            ppchv_pkg::OFS_DIR:      r_dir     <= w_data[5:0];
            ppchv_pkg::OFS_PULL_EN:  r_pen     <= w_data[5:0];
            ppchv_pkg::OFS_PULL_SEL: r_psel    <= w_data[5:0];
            ppchv_pkg::OFS_EV_EN:    r_ev_en   <= w_data[7:0];
            ppchv_pkg::OFS_DRV_RED:  r_drv_red <= w_data[2:0];
            ppchv_pkg::OFS_OPEN_DR:  r_od      <= w_data[5:0];
            ppchv_pkg::OFS_HV_AEN:   r_aen     <= w_data[5:0];
            ppchv_pkg::OFS_HV_DIR:   r_hdir    <= w_data[5:0];
            ppchv_pkg::OFS_HV_BYP:   r_byp     <= w_data[5:0];
            ppchv_pkg::OFS_HV_TEST:  r_test    <= w_data[5:0];
            ppchv_pkg::OFS_HV_RATIO: r_ratio   <= w_data[5:0];
            ppchv_pkg::OFS_HV_DIEN:  r_dien    <= w_data[5:0];
            ppchv_pkg::OFS_HV_POL:   r_pol     <= w_data[5:0];
            ppchv_pkg::OFS_HV_EV_EN: r_hev_en  <= w_data[5:0];
            ppchv_pkg::OFS_EXT_CTRL: r_ext     <= w_data[1:0];
            default:                 r_ext     <= r_ext;
         endcase
      end
   end

   // ==========================================================
   // glitch filters
   localparam int NPIN_L = ppchv_pkg::NPIN;
   logic [7:0] hist_p [NPIN_L];
   logic [7:0] hist_l [NPIN_L];
   logic       rc_d;
   logic       sample;
   logic [5:0] hit_p, hit_l;
   logic [5:0] l_smp;

   function automatic logic ppchv_hit(input logic [7:0] h,
                                      input logic rise);
      ppchv_hit = rise ? (h == ppchv_pkg::HIST_RISE)
                       : (h == ppchv_pkg::HIST_FALL);
   endfunction

   // stop mode samples on rc rising edges, otherwise every bus clock
   assign sample = stop_mode ? (rc_s & ~rc_d) : 1'b1;
   // an off buffer feeds the passive level so no false edge appears
   assign l_smp  = (hv_buffer_on & l_s) | (~hv_buffer_on & ~r_pol);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rc_d <= 1'b0;
         for (int i = 0; i < NPIN_L; i++) begin
            hist_p[i] <= 8'h00;
            hist_l[i] <= 8'h00;
         end
      end else begin
         rc_d <= rc_s;
         for (int i = 0; i < NPIN_L; i++) begin
            if (sample) begin
               // accepted edge restarts the sequence from active
               hist_p[i] <= hit_p[i] ? {8{r_psel[i]}}
                                     : {hist_p[i][6:0], p_s[i]};
               hist_l[i] <= hit_l[i] ? {8{r_pol[i]}}
                                     : {hist_l[i][6:0], l_smp[i]};
            end
         end
      end
   end

   always_comb begin
      for (int i = 0; i < NPIN_L; i++) begin
         hit_p[i] = sample & ppchv_hit(hist_p[i], r_psel[i]);
         hit_l[i] = sample & ppchv_hit(hist_l[i], r_pol[i]);
      end
   end

   // ==========================================================
   // sticky flags, set wins over write-one clear
   logic [7:0] clr_p;
   logic [5:0] clr_l;
   assign clr_p = (wr_cfg && aw_addr == ppchv_pkg::OFS_EV_FLAG)
                  ? w_data[7:0] : 8'h00;
   assign clr_l = (wr_cfg && aw_addr == ppchv_pkg::OFS_HV_EV_FLG)
                  ? w_data[5:0] : 6'h00;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         f_p  <= ppchv_pkg::RST_6;
         f_l  <= ppchv_pkg::RST_6;
         f_oc <= 2'b00;
      end else begin
         f_p  <= hit_p | (f_p & ~clr_p[5:0]);
         f_l  <= hit_l | (f_l & ~clr_l);
         f_oc <= (oc_s & ~{2{stop_mode}}) |
                 (f_oc & ~clr_p[7:6]);
      end
   end

   // ==========================================================
   // external request pins, no filtering
   logic ext_d_n;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_d_n  <= 1'b1;
         ext_pend <= 1'b0;
      end else begin
         ext_d_n <= ext_s_n;
         if (!r_ext[ppchv_pkg::EXT_EN]) begin
            ext_pend <= 1'b0;
         end else if (ext_d_n && !ext_s_n) begin
            ext_pend <= 1'b1;
         end else if (wr_cfg && aw_addr == ppchv_pkg::OFS_EXT_CTRL &&
                      w_data[ppchv_pkg::EXT_PEND]) begin
            ext_pend <= 1'b0;
         end
      end
   end

   // ==========================================================
   // rc oscillator phase in stop
   logic [$clog2(ppchv_pkg::RC_PHASE_CYC+1)-1:0] rc_cnt;
   logic [5:0] p_d, l_d;
   logic       trig;
   assign trig = |(((p_s ^ p_d) & ~f_p) | ((l_smp ^ l_d) & ~f_l));
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rc_cnt <= '0;
         p_d    <= 6'h00;
         l_d    <= 6'h00;
      end else begin
         p_d <= p_s;
         l_d <= l_smp;
         if (stop_mode && trig) begin
            rc_cnt <= ($bits(rc_cnt))'(ppchv_pkg::RC_PHASE_CYC);
         end else if (!stop_mode) begin
            rc_cnt <= '0;
         end else if (rc_cnt != '0) begin
            rc_cnt <= rc_cnt - 1'b1;
         end
      end
   end

   // ==========================================================
   // pin control and outputs
   logic [5:0] is_out, drv, kill;
   always_comb begin
      // peripheral output outranks a forced-input peripheral
      is_out = periph_out_en | (~periph_in_en & r_dir);
      drv    = (periph_out_en & periph_data) |
               (~periph_out_en & r_data);
      kill   = {3'b000, f_oc[1], 1'b0, f_oc[0]};
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_out        <= 6'h00;
         pin_oe         <= 6'h00;
         pull_up_on     <= 6'h00;
         pull_down_on   <= 6'h00;
         drive_full     <= 3'h7;
         hv_buffer_on   <= 6'h00;
         hv_analog_on   <= 6'h00;
         hv_divider_sel <= 6'h00;
         hv_direct_on   <= 6'h00;
         hv_conv_bypass <= 6'h00;
         rc_osc_enable  <= 1'b0;
         port_p_irq     <= 1'b0;
         port_l_irq     <= 1'b0;
         oc_irq         <= 1'b0;
         ext_irq        <= 1'b0;
         nmi_req        <= 1'b0;
         wakeup         <= 1'b0;
      end else begin
         pin_out      <= drv & ~kill;
         // open drain drives only the low level
         pin_oe       <= is_out & ~(r_od & drv & ~kill);
         pull_up_on   <= r_pen & ~r_psel & ~is_out;
         pull_down_on <= r_pen & r_psel & ~is_out & ~r_od;
         drive_full   <= ~r_drv_red;
         hv_buffer_on <= stop_mode ? r_dien
                       : (r_aen & r_test & ~r_hdir) |
                         (~r_aen & r_dien);
         hv_analog_on   <= r_aen & ~{6{stop_mode}};
         hv_divider_sel <= r_ratio;
         hv_direct_on   <= r_aen & r_hdir;
         hv_conv_bypass <= r_aen & r_hdir & r_byp;
         rc_osc_enable  <= rc_cnt != '0;
         port_p_irq     <= |(f_p & r_ev_en[5:0]);
         port_l_irq     <= |(f_l & r_hev_en);
         oc_irq         <= (f_oc[0] & r_ev_en[ppchv_pkg::OC_EN_P0]) |
                           (f_oc[1] & r_ev_en[ppchv_pkg::OC_EN_P2]);
         ext_irq        <= r_ext[ppchv_pkg::EXT_EN] &
                           (r_ext[ppchv_pkg::EXT_EDGE] ? ext_pend
                                                       : ~ext_s_n);
         nmi_req        <= nmi_unmasked & ~nmi_s_n;
         wakeup         <= |(f_p & r_ev_en[5:0]) | |(f_l & r_hev_en) |
                           (r_ext[ppchv_pkg::EXT_EN] & ~ext_s_n) |
                           (nmi_unmasked & ~nmi_s_n);
      end
   end
endmodule
`default_nettype wire

// ===== bench/ppchv_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ppchv_properties (
   input wire logic        aclk, aresetn,                 // clock, reset
   input wire logic        s_axi_bvalid, s_axi_bready,    // write answer
   input wire logic        s_axi_arvalid, s_axi_arready,  // read address
   input wire logic        s_axi_rvalid, s_axi_rready,    // read answer
   input wire logic [31:0] s_axi_rdata,                   // read data
   input wire logic [5:0]  pin_out, pin_oe,               // pin drive
   input wire logic [5:0]  pull_up_on, pull_down_on,      // pull devices
   input wire logic [2:0]  drive_full,                    // drive strength
   input wire logic        oc_irq, ext_irq,               // requests
   input wire logic        nmi_req, nmi_unmasked          // non-maskable
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ==========================================================
   // pins and requests
   property p_pull_off_out; (pin_oe & (pull_up_on | pull_down_on)) == 6'h00; endproperty
   a_pull_off_out: assert property (p_pull_off_out) else $error("pull on driven pin");
   property p_pull_one; (pull_up_on & pull_down_on) == 6'h00; endproperty
   a_pull_one: assert property (p_pull_one) else $error("both pulls on");
   property p_drive_rst; disable iff (1'b0) !aresetn |=> drive_full == 3'h7; endproperty
   a_drive_rst: assert property (p_drive_rst) else $error("drive not full");
   property p_req_rst; disable iff (1'b0) !aresetn |=> !ext_irq && !oc_irq; endproperty
   a_req_rst: assert property (p_req_rst) else $error("request after reset");
   property p_nmi_gate; nmi_req |-> $past(nmi_unmasked); endproperty
   a_nmi_gate: assert property (p_nmi_gate) else $error("nmi before init");
   property p_oc_low; $rose(oc_irq) |-> !(pin_out[0] && pin_out[2]); endproperty
   a_oc_low: assert property (p_oc_low) else $error("flagged pin still high");
   // ==========================================================
   // register bus
   property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_r_answer: assert property (p_r_answer) else $error("no read answer");
   property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_ar_block: assert property (p_ar_block) else $error("second read taken");
endmodule
`default_nettype wire

// ===== bench/ppchv_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
module ppchv_pins_model (
   input  wire logic       aclk,                      // bus clock
   input  wire logic [5:0] pin_out, pin_oe,           // device drive
   input  wire logic [5:0] pull_up_on, pull_down_on,  // device pulls
   input  wire logic [5:0] ext_en, ext_val,           // outside driver
   output logic      [5:0] pin_in                     // resolved level
);
   // undriven pins wander so a stale level never looks valid
   logic [5:0] wander = 6'h15;
   always_ff @(posedge aclk) wander <= ~wander;
   always_comb
      for (int i = 0; i < 6; i++)
         pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                     pull_up_on[i] ? 1'b1 : pull_down_on[i] ? 1'b0 : wander[i];
endmodule
`default_nettype wire

// ===== bench/ppchv_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module ppchv_tb_top;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, ext_req_pin_n = 1, nmi_pin_n = 1;
   logic nmi_unmasked = 0, stop_mode = 0, rc_clk = 0;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, rdv, seed = 32'h4;
   logic [31:0] s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [5:0]  periph_out_en = '0, periph_in_en = '0, periph_data = '0, hv_pin_in = '0;
   logic [5:0]  ext_en = '0, ext_val = '0, pin_in, pin_out, pin_oe, pull_up_on, pull_down_on;
   logic [5:0]  hv_buffer_on, hv_analog_on, hv_divider_sel, hv_direct_on, hv_conv_bypass;
   logic [1:0]  oc_detect = '0, s_axi_bresp, s_axi_rresp, rrv;
   logic [2:0]  drive_full;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic rc_osc_enable, port_p_irq, port_l_irq, oc_irq, ext_irq, nmi_req, wakeup;
   int bad_count = 0, comparisons = 0;
   ppchv_top u_dut (.*);
   ppchv_pins_model u_pins (.aclk, .pin_out, .pin_oe, .pull_up_on, .pull_down_on,
                            .ext_en, .ext_val, .pin_in);
   initial forever #2.5 aclk = ~aclk;
   always @(posedge aclk) rc_clk <= ~rc_clk;
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      return x ^ (x << 5);
   endfunction
   task automatic cyc(input int n); repeat (n) @(posedge aclk); endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {24'h0, a, d, 3'h7};
      forever begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {24'h0, a, 2'h3};
      forever begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      {rdv, rrv} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'b0;
   endtask
   task automatic tend(input string s); $display("test %s done", s); endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // ==========================================================
   // watchdog
   initial begin
      cyc(20000);
      bad_count++;
      stop_test();
   end
   // ==========================================================
   // tests
   initial begin
      logic [7:0] m;
      cyc(3);
      aresetn <= 1'b1;
      cyc(1);
      `CHK({drive_full, hv_buffer_on, ext_irq}, 10'h380)
      tend("reset");
      for (logic [7:0] o = 8'h08; o <= 8'h40; o += 8'h04) begin
         seed = xs(seed);
         m = o == 8'h14 ? 8'hFF : o == 8'h1C ? 8'h07 : 8'h3F;
         if (o == 8'h18) continue;
         wr(o, seed);
         rd(o);
         `CHK(rdv, {24'h0, seed[7:0] & m})
         wr(o, 32'h0);
      end
      rd(8'h80);
      `CHK({rrv, rdv}, {ppchv_pkg::RESP_ERR, 32'h0})
      tend("registers");
      wr(8'h0C, 32'h3F);
      wr(8'h10, 32'h0F);
      cyc(2);
      `CHK({pull_up_on, pull_down_on}, 12'hC0F)
      wr(8'h08, 32'h03);
      cyc(2);
      `CHK({pull_up_on, pull_down_on}, 12'hC0C)
      wr(8'h08, 32'h00);
      wr(8'h20, 32'h3F);
      cyc(2);
      `CHK(pull_down_on, 6'h00)
      wr(8'h20, 32'h00);
      wr(8'h08, 32'h01);
      {periph_out_en, periph_data, periph_in_en} <= {6'h20, 6'h20, 6'h01};
      cyc(3);
      `CHK({pin_oe[5], pin_out[5], pull_up_on[5], pin_oe[0]}, 4'hC)
      {periph_out_en, periph_in_en} <= 12'h000;
      wr(8'h08, 32'h00);
      wr(8'h0C, 32'h00);
      tend("pins");
      seed = xs(seed);
      {ext_en, ext_val} <= {6'h3F, seed[5:0]};
      cyc(4);
      rd(8'h04);
      `CHK(rdv, {26'h0, ext_val})
      rd(8'h00);
      `CHK(rdv, {26'h0, ext_val})
      wr(8'h10, 32'h01);
      ext_val <= 6'h00;
      cyc(12);
      wr(8'h18, 32'hFF);
      wr(8'h14, 32'h01);
      ext_val <= 6'h01;
      cyc(3);
      ext_val <= 6'h00;
      cyc(12);
      `CHK(port_p_irq, 1'b0)
      ext_val <= 6'h01;
      cyc(12);
      `CHK(port_p_irq, 1'b1)
      wr(8'h18, 32'h01);
      cyc(3);
      `CHK(port_p_irq, 1'b0)
      tend("events");
      wr(8'h14, 32'h40);
      wr(8'h08, 32'h01);
      wr(8'h00, 32'h01);
      oc_detect <= 2'h1;
      cyc(6);
      `CHK({oc_irq, pin_out[0]}, 2'h2)
      oc_detect <= 2'h0;
      cyc(4);
      `CHK(pin_out[0], 1'b0)
      wr(8'h18, 32'h40);
      cyc(3);
      `CHK({oc_irq, pin_out[0]}, 2'h1)
      wr(8'h1C, 32'h05);
      cyc(2);
      `CHK(drive_full, 3'h2)
      ext_req_pin_n <= 1'b0;
      wr(8'h4C, 32'h01);
      cyc(4);
      `CHK(ext_irq, 1'b1)
      wr(8'h4C, 32'h00);
      cyc(2);
      `CHK(ext_irq, 1'b0)
      {ext_req_pin_n, nmi_pin_n} <= 2'h2;
      cyc(4);
      `CHK(nmi_req, 1'b0)
      nmi_unmasked <= 1'b1;
      cyc(3);
      `CHK(nmi_req, 1'b1)
      wr(8'h4C, 32'h03);
      ext_req_pin_n <= 1'b0;
      cyc(4);
      ext_req_pin_n <= 1'b1;
      cyc(4);
      `CHK(ext_irq, 1'b1)
      tend("requests");
      for (int k = 0; k < 5; k++) begin
         m = k == 0 ? 8'h38 : k == 1 ? 8'h24 : k == 2 ? 8'h30 : 8'h28;
         if (k < 4) wr(m, 32'h3F);
         else stop_mode <= 1'b1;
         cyc(3);
         `CHK(hv_buffer_on, k[0] ? 6'h00 : 6'h3F)
         `CHK({hv_analog_on, hv_direct_on},
              {k % 4 ? 6'h3F : 6'h00, k > 2 ? 6'h3F : 6'h00})
      end
      wr(8'h40, 32'h01);
      cyc(4);
      wr(8'h44, 32'h3F);
      hv_pin_in <= 6'h01;
      cyc(20);
      `CHK(rc_osc_enable, 1'b1)
      hv_pin_in <= 6'h00;
      cyc(20);
      `CHK(port_l_irq, 1'b1)
      tend("high voltage");
      stop_test();
   end
endmodule
bind ppchv_top ppchv_properties u_chk (.*);
`default_nettype wire
